/* File: bsp_fifo.sv */
// Parameterised valid/ready FIFO for read data
`timescale 1ns/1ps
module bsp_fifo #(
    parameter int W     = bsp_pkg::DATA_W,
    parameter int DEPTH = bsp_pkg::FIFO_DEPTH
) (
    input  wire logic                     clk_i,       // Clock
    input  wire logic                     reset_n_i,   // Async reset, low active
    input  wire logic                     in_valid_i,  // Push request
    output logic                          in_ready_o,  // Room available
    input  wire logic [W-1:0]             in_data_i,   // Push data
    output logic                          out_valid_o, // Data available
    input  wire logic                     out_ready_i, // Pop request
    output logic [W-1:0]                  out_data_o,  // Head data
    output logic [$clog2(DEPTH+1)-1:0]    level_o      // Words held
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0]  mem_q [DEPTH];
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic [CW-1:0] count_q;
    logic          push;
    logic          pop;

    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign in_ready_o  = (count_q != CW'(DEPTH));
    assign out_valid_o = (count_q != '0);
    assign out_data_o  = mem_q[rd_ptr_q];
    assign level_o     = count_q;

    // Storage, no reset needed
    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

    // Pointers wrap at DEPTH so non power of two depths work
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            end
            count_q <= count_q + CW'(push) - CW'(pop);
        end
    end
endmodule

/* File: bsp_if.sv */
// Pin-level link between the burst SRAM and its memory controller
`timescale 1ns/1ps
interface bsp_if #(
    parameter int AW = bsp_pkg::ADDR_W,
    parameter int DW = bsp_pkg::DATA_W
);
    localparam int NB = DW / bsp_pkg::LANE_W;

    logic          k_run;                // Input clocks running
    logic          k_rise;               // This rise is the positive clock, else negative
    logic [AW-1:0] addr;                 // Shared address bus
    logic          read_port_select_n;   // Read start, low active
    logic          write_port_select_n;  // Write start, low active
    logic [NB-1:0] byte_write_select_n;  // Per-lane write enables, low active
    logic [DW-1:0] d;                    // Write data
    logic [DW-1:0] q;                    // Read data from the device
    logic          q_oe_n;               // Low while device drives q, high = floating

    modport sram (
        input  k_run, k_rise, addr, read_port_select_n, write_port_select_n,
        input  byte_write_select_n, d,
        output q, q_oe_n
    );
    modport ctrl (
        output k_run, k_rise, addr, read_port_select_n, write_port_select_n,
        output byte_write_select_n, d,
        input  q, q_oe_n
    );
endinterface

/* File: bsp_link_props.sv */
// Pin-level checker for the burst SRAM link
`timescale 1ns/1ps
module bsp_link_props #(
    parameter int AW = 8,
    parameter int DW = 18
) (
    input wire logic            clk_i,                // Clock
    input wire logic            reset_n_i,            // Async reset, low active
    input wire logic            k_run,                // Clocks running
    input wire logic            k_rise,               // Positive rise marker
    input wire logic [AW-1:0]   addr,                 // Burst address
    input wire logic            read_port_select_n,   // Read start, low
    input wire logic            write_port_select_n,  // Write start, low
    input wire logic [DW/9-1:0] byte_write_select_n,  // Lane enables, low
    input wire logic [DW-1:0]   d,                    // Write word
    input wire logic [DW-1:0]   q,                    // Read word
    input wire logic            q_oe_n                // Read drive enable, low
);
    logic       rd_last_q;  // Read started on last positive rise
    logic       wr_last_q;  // Write started on last positive rise
    logic [7:0] rd_hist_q;  // Honoured read starts, one bit per running edge
    logic       rd_go;
    logic       wr_go;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    // Starts the device honours; a repeat on the next positive rise is dropped
    assign rd_go = k_run && k_rise && !read_port_select_n && !rd_last_q;
    assign wr_go = k_run && k_rise && !write_port_select_n && !wr_last_q;

    // Start history, only positive rises count
    always_ff @(posedge clk_i or negedge reset_n_i)
        if (!reset_n_i)
        begin
            rd_last_q <= 1'b0;
            wr_last_q <= 1'b0;
        end
        else if (k_run && k_rise)
        begin
            rd_last_q <= rd_go;
            wr_last_q <= wr_go;
        end

    // Shift register, not an age counter, so overlapped reads stay visible
    always_ff @(posedge clk_i or negedge reset_n_i)
        if (!reset_n_i)
            rd_hist_q <= 8'h00;
        else if (k_run)
            rd_hist_q <= {rd_hist_q[6:0], rd_go};

    property p_rd_lat;    rd_go |-> ##5 !q_oe_n [*4]; endproperty
    property p_rd_float;  !q_oe_n |-> (|rd_hist_q[7:4]); endproperty
    property p_freeze;    !k_run |=> $stable(q) && $stable(q_oe_n); endproperty
    property p_k_alt;     k_run && $past(k_run) |-> k_rise != $past(k_rise); endproperty
    property p_sel_pos;   (!read_port_select_n || !write_port_select_n) |-> k_run && k_rise;
    endproperty
    property p_rd_gap;    rd_go |=> read_port_select_n [*3]; endproperty
    property p_wr_gap;    wr_go |=> write_port_select_n [*5]; endproperty
    property p_one_start; !(!read_port_select_n && !write_port_select_n); endproperty

    a_rd_lat:    assert property (p_rd_lat) else $error("read data late or short");
    a_rd_float:  assert property (p_rd_float) else $error("read bus driven idle");
    a_freeze:    assert property (p_freeze) else $error("outputs moved while stopped");
    a_k_alt:     assert property (p_k_alt) else $error("rises not alternating");
    a_sel_pos:   assert property (p_sel_pos) else $error("select off positive rise");
    a_rd_gap:    assert property (p_rd_gap) else $error("reads too close");
    a_wr_gap:    assert property (p_wr_gap) else $error("writes too close");
    a_one_start: assert property (p_one_start) else $error("both selects low");

    c_rd:   cover property (rd_go);
    c_wr:   cover property (wr_go);
    c_stop: cover property (!k_run ##1 k_run);
endmodule

/* File: bsp_mem_ctrl.sv */
// Memory controller end: issues bursts, feeds write words, buffers reads
`timescale 1ns/1ps
module bsp_mem_ctrl #(
    parameter int AW    = bsp_pkg::ADDR_W,
    parameter int DW    = bsp_pkg::DATA_W,
    parameter int DEPTH = bsp_pkg::FIFO_DEPTH
) (
    input  wire logic                      clk_i,        // Clock, one edge per link rise
    input  wire logic                      reset_n_i,    // Async reset, low active
    bsp_if.ctrl                            port,         // Pins toward the SRAM
    input  wire logic                      clk_stop_i,   // Request clock stop when idle
    input  wire logic                      cmd_valid_i,  // Command offered
    output logic                           cmd_ready_o,  // Command slot free
    input  wire logic                      cmd_write_i,  // 1 write burst, 0 read burst
    input  wire logic [AW-1:0]             cmd_addr_i,   // Burst start address
    input  wire logic [bsp_pkg::BURST_LEN*DW-1:0] cmd_wdata_i,  // Write words, word 0 low
    input  wire logic [bsp_pkg::BURST_LEN*(DW/bsp_pkg::LANE_W)-1:0] cmd_bws_n_i, // Lane selects
    output logic                           rd_valid_o,   // Read word available
    input  wire logic                      rd_ready_i,   // Read word taken
    output logic [DW-1:0]                  rd_data_o     // Read word
);
    localparam int NB = DW / bsp_pkg::LANE_W;
    localparam int BL = bsp_pkg::BURST_LEN;
    localparam int CW = $clog2(DEPTH + 1);
    localparam int SW = bsp_pkg::RD_SH_LEN;

    logic                     full_q;
    logic                     c_write_q;
    logic [AW-1:0]            c_addr_q;
    logic [BL*DW-1:0]         c_wdata_q;
    logic [BL*NB-1:0]         c_bws_q;
    logic [BL*DW-1:0]         w_data_q;
    logic [BL*NB-1:0]         w_bws_q;
    logic                     run_q;
    logic                     k_rise_q;
    logic [bsp_pkg::WR_SH_LEN-1:0] wr_sh_q;
    logic [SW-1:0]            rd_sh_q;
    logic [AW-1:0]            addr_q;
    logic                     rps_n_q;
    logic                     wps_n_q;
    logic [DW-1:0]            d_q;
    logic [NB-1:0]            bws_n_q;
    logic                     accept;
    logic                     slot;
    logic                     issue_rd;
    logic                     issue_wr;
    logic                     capture;
    logic                     fifo_in_ready;
    logic [CW-1:0]            fifo_level;
    logic [CW+3:0]            reserved;
    logic                     idle;

    // Words promised to reads in flight, counted conservatively
    always_comb
    begin
        reserved = (CW+4)'(fifo_level) + (CW+4)'(BL);
        for (int i = 0; i < SW; i++)
        begin
            reserved = reserved + (rd_sh_q[i] ? (CW+4)'(BL) : '0);
        end
    end

    // Issue only on an edge that the SRAM sees as a negative rise, so the select lands on the next positive rise
    assign slot     = run_q && !k_rise_q && full_q;
    assign issue_rd = slot && !c_write_q && (rd_sh_q[bsp_pkg::RD_GAP_BITS-1:0] == '0)
                      && fifo_in_ready && (reserved <= (CW+4)'(DEPTH));
    assign issue_wr = slot && c_write_q
                      && (wr_sh_q[bsp_pkg::WR_GAP_BITS-1:0] == '0);
    assign accept   = cmd_valid_i && cmd_ready_o;
    assign capture  = run_q && (rd_sh_q[SW-1:bsp_pkg::RD_CAP_FIRST] != '0);
    assign idle     = (rd_sh_q == '0) && (wr_sh_q == '0);

    // Command holding slot; ready comes from a register
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            full_q      <= 1'b0;
            cmd_ready_o <= 1'b0;
            c_write_q   <= 1'b0;
            c_addr_q    <= '0;
            c_wdata_q   <= '0;
            c_bws_q     <= '1;
        end
        else
        begin
            full_q      <= (full_q && !(issue_rd || issue_wr)) || accept;
            cmd_ready_o <= !((full_q && !(issue_rd || issue_wr)) || accept);
            if (accept)
            begin
                c_write_q <= cmd_write_i;
                c_addr_q  <= cmd_addr_i;
                c_wdata_q <= cmd_wdata_i;
                c_bws_q   <= cmd_bws_n_i;
            end
        end
    end

    // Link clock model; stops only between bursts after a positive rise,
    // which leaves both clocks parked high
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            run_q    <= 1'b0;
            k_rise_q <= 1'b0;
        end
        else if (!run_q)
        begin
            run_q <= !clk_stop_i;
        end
        else
        begin
            k_rise_q <= !k_rise_q;
            if (clk_stop_i && idle && k_rise_q && !(issue_rd || issue_wr))
            begin
                run_q <= 1'b0;
            end
        end
    end

    // Burst schedules; a set bit walks one place per link rise
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wr_sh_q  <= '0;
            rd_sh_q  <= '0;
            w_data_q <= '0;
            w_bws_q  <= '1;
        end
        else if (run_q)
        begin
            wr_sh_q <= {wr_sh_q[bsp_pkg::WR_SH_LEN-2:0], issue_wr};
            rd_sh_q <= {rd_sh_q[SW-2:0], issue_rd};
            if (issue_wr)
            begin
                w_data_q <= c_wdata_q;
                w_bws_q  <= c_bws_q;
            end
        end
    end

    // Pin drivers: selects low for one positive rise, words on both rises
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            addr_q  <= '0;
            rps_n_q <= 1'b1;
            wps_n_q <= 1'b1;
            d_q     <= '0;
            bws_n_q <= '1;
        end
        else if (run_q)
        begin
            rps_n_q <= !issue_rd;
            wps_n_q <= !issue_wr;
            bws_n_q <= '1;
            if (issue_rd || issue_wr)
            begin
                addr_q <= c_addr_q;
            end
            for (int b = 0; b < BL; b++)
            begin
                if (wr_sh_q[bsp_pkg::WR_DRV_FIRST + b])
                begin
                    d_q     <= w_data_q[b*DW +: DW];
                    bws_n_q <= w_bws_q[b*NB +: NB];
                end
            end
        end
    end

    // Read words queue here; the user may stall, issue waits for room
    bsp_fifo #(
        .W     (DW),
        .DEPTH (DEPTH)
    ) u_rd_fifo (
        .clk_i       (clk_i),
        .reset_n_i   (reset_n_i),
        .in_valid_i  (capture),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (port.q),
        .out_valid_o (rd_valid_o),
        .out_ready_i (rd_ready_i),
        .out_data_o  (rd_data_o),
        .level_o     (fifo_level)
    );

    assign port.k_run               = run_q;
    assign port.k_rise              = k_rise_q;
    assign port.addr                = addr_q;
    assign port.read_port_select_n  = rps_n_q;
    assign port.write_port_select_n = wps_n_q;
    assign port.d                   = d_q;
    assign port.byte_write_select_n = bws_n_q;
endmodule

/* File: bsp_pkg.sv */
// Shared constants for the burst SRAM port and its controller
package bsp_pkg;
    localparam int ADDR_W       = 8;   // Default address width of the model array
    localparam int DATA_W       = 18;  // Default word width (18 or 36)
    localparam int LANE_W       = 9;   // Bits per byte lane
    localparam int BURST_LEN    = 4;   // Words per burst
    localparam int WR_LAT_EDGES = 2;   // Clock rises from write start to first data word
    localparam int RD_LAT_EDGES = 4;   // Clock rises from read start to first read word
    localparam int FIFO_DEPTH   = 8;   // Read data buffer depth
    localparam int AGE_W        = 3;   // Width of pending-operation age counters
    localparam int BEAT_W       = 2;   // Width of a burst beat index
    localparam int WR_SH_LEN    = 5;   // Controller write schedule length
    localparam int RD_SH_LEN    = 9;   // Controller read schedule length
    localparam int WR_GAP_BITS  = 4;   // Write schedule bits that block a new write
    localparam int RD_GAP_BITS  = 3;   // Read schedule bits that block a new read
    localparam int RD_CAP_FIRST = 5;   // Read schedule bit of first capture
    localparam int WR_DRV_FIRST = 1;   // Write schedule bit of first driven word
endpackage

/* File: bsp_sram_device.sv */
// Burst-of-four SRAM end: separate read and write ports, shared address
// Summary of operation
// - Write words taken at t+1 and t+2 rises
// - Read words driven at t+2 and t+3 rises
// - Stopped clocks freeze all data state
// - Controller parks stopped clocks high
// - Power-up deselected, read outputs floating
// - Select starting previous rise is ignored
// - Back-to-back same-port requests: second dropped
// - Two lane selects gate 18-bit word lanes
// - Four lane selects gate 36-bit word lanes
// - Lane selects sampled per data word
// - Data moves on both clock rises
// - Burst addresses A, A+1, A+2, A+3
// - Simultaneous starts: read taken, write dropped
// - Read after write returns new data
`timescale 1ns/1ps
module bsp_sram_device #(
    parameter int AW = bsp_pkg::ADDR_W,
    parameter int DW = bsp_pkg::DATA_W
) (
    input  wire logic clk_i,      // One edge per input clock rise
    input  wire logic reset_n_i,  // Power-up reset, low active
    bsp_if.sram       port,       // Pins toward the controller
    output logic      rd_busy_o,  // Read burst pending or in flight
    output logic      wr_busy_o   // Write burst pending or in flight
);
    localparam int NB   = DW / bsp_pkg::LANE_W;
    localparam int LW   = bsp_pkg::LANE_W;
    localparam int BW   = bsp_pkg::BEAT_W;
    localparam int AGW  = bsp_pkg::AGE_W;
    localparam int LAST = bsp_pkg::BURST_LEN - 1;

    logic [DW-1:0]  mem_q [2**AW];
    logic           step;
    logic           krise;
    logic           prev_rd_q;
    logic           prev_wr_q;
    logic           start_rd;
    logic           start_wr;
    logic           rp_vld_q;
    logic [AW-1:0]  rp_addr_q;
    logic [AGW-1:0] rp_age_q;
    logic           rb_vld_q;
    logic [AW-1:0]  rb_base_q;
    logic [BW-1:0]  rb_beat_q;
    logic           wp_vld_q;
    logic [AW-1:0]  wp_addr_q;
    logic [AGW-1:0] wp_age_q;
    logic           wb_vld_q;
    logic [AW-1:0]  wb_base_q;
    logic [BW-1:0]  wb_beat_q;
    logic           rd_first;
    logic           wr_first;
    logic           rd_beat;
    logic           wr_beat;
    logic [AW-1:0]  rd_addr;
    logic [AW-1:0]  wr_addr;
    logic [DW-1:0]  q_q;
    logic           q_oe_n_q;

    // Nothing moves while the input clocks are stopped
    assign step  = port.k_run;
    assign krise = step && port.k_rise;

    // Selects only count on a positive rise and not right after a start
    assign start_rd = krise && !port.read_port_select_n && !prev_rd_q;
    assign start_wr = krise && !port.write_port_select_n && !prev_wr_q
                      && !start_rd;

    // First word comes from the pending slot, the rest from the burst slot
    assign rd_first = rp_vld_q && (rp_age_q == AGW'(bsp_pkg::RD_LAT_EDGES));
    assign wr_first = wp_vld_q && (wp_age_q == AGW'(bsp_pkg::WR_LAT_EDGES));
    assign rd_beat  = step && (rd_first || rb_vld_q);
    assign wr_beat  = step && (wr_first || wb_vld_q);
    assign rd_addr  = rd_first ? rp_addr_q : AW'(rb_base_q + AW'(rb_beat_q));
    assign wr_addr  = wr_first ? wp_addr_q : AW'(wb_base_q + AW'(wb_beat_q));

    // Start history, updated only on positive rises
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            prev_rd_q <= 1'b0;
            prev_wr_q <= 1'b0;
        end
        else if (krise)
        begin
            prev_rd_q <= start_rd;
            prev_wr_q <= start_wr;
        end
    end

    // Read pending and burst slots; a new start may load while a burst drains
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rp_vld_q  <= 1'b0;
            rp_addr_q <= '0;
            rp_age_q  <= '0;
            rb_vld_q  <= 1'b0;
            rb_base_q <= '0;
            rb_beat_q <= '0;
        end
        else if (step)
        begin
            if (start_rd)
            begin
                rp_vld_q  <= 1'b1;
                rp_addr_q <= port.addr;
                rp_age_q  <= AGW'(1);
            end
            else if (rd_first)
            begin
                rp_vld_q <= 1'b0;
            end
            else if (rp_vld_q)
            begin
                rp_age_q <= rp_age_q + 1'b1;
            end
            if (rd_first)
            begin
                rb_vld_q  <= 1'b1;
                rb_base_q <= rp_addr_q;
                rb_beat_q <= BW'(1);
            end
            else if (rb_vld_q)
            begin
                rb_vld_q  <= (rb_beat_q != BW'(LAST));
                rb_beat_q <= rb_beat_q + 1'b1;
            end
        end
    end

    // Write pending and burst slots, same scheme with a shorter latency
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wp_vld_q  <= 1'b0;
            wp_addr_q <= '0;
            wp_age_q  <= '0;
            wb_vld_q  <= 1'b0;
            wb_base_q <= '0;
            wb_beat_q <= '0;
        end
        else if (step)
        begin
            if (start_wr)
            begin
                wp_vld_q  <= 1'b1;
                wp_addr_q <= port.addr;
                wp_age_q  <= AGW'(1);
            end
            else if (wr_first)
            begin
                wp_vld_q <= 1'b0;
            end
            else if (wp_vld_q)
            begin
                wp_age_q <= wp_age_q + 1'b1;
            end
            if (wr_first)
            begin
                wb_vld_q  <= 1'b1;
                wb_base_q <= wp_addr_q;
                wb_beat_q <= BW'(1);
            end
            else if (wb_vld_q)
            begin
                wb_vld_q  <= (wb_beat_q != BW'(LAST));
                wb_beat_q <= wb_beat_q + 1'b1;
            end
        end
    end

    // Each word lands in the array at once, so a later read sees it
    // without a separate bypass path
    always_ff @(posedge clk_i)
    begin
        if (wr_beat)
        begin
            for (int l = 0; l < NB; l++)
            begin
                if (!port.byte_write_select_n[l])
                begin
                    mem_q[wr_addr][l*LW +: LW] <= port.d[l*LW +: LW];
                end
            end
        end
    end

    // Read output register; floats between bursts and from power-up
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            q_q      <= '0;
            q_oe_n_q <= 1'b1;
        end
        else if (step)
        begin
            if (rd_beat)
            begin
                q_q      <= mem_q[rd_addr];
                q_oe_n_q <= 1'b0;
            end
            else
            begin
                q_oe_n_q <= 1'b1;
            end
        end
    end

    // Status flags, one edge behind the slots
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rd_busy_o <= 1'b0;
            wr_busy_o <= 1'b0;
        end
        else
        begin
            rd_busy_o <= rp_vld_q || rb_vld_q;
            wr_busy_o <= wp_vld_q || wb_vld_q;
        end
    end

    assign port.q      = q_q;
    assign port.q_oe_n = q_oe_n_q;
endmodule

/* File: tb_quad_rate_sram_burst_port.sv */
// Self-checking bench for the burst SRAM and its controller, joined back to back
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_total++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_quad_rate_sram_burst_port;
    logic        clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        clk_stop, cmd_valid, cmd_write, rd_ready, cmd_ready_o, rd_valid_o, ok;
    logic        rd_busy, wr_busy;
    logic [7:0]  cmd_addr, cmd_bws_n;
    logic [71:0] cmd_wdata;
    logic [17:0] rd_data;
    logic [17:0] mem [256];
    int          err_total = 0;
    int          tests_run = 0;
    int          cyc = 0;

    bsp_if lnk ();
    bsp_sram_device i_bsp_sram_device (.clk_i(clk_i), .reset_n_i(reset_n_i), .port(lnk),
        .rd_busy_o(rd_busy), .wr_busy_o(wr_busy));
    bsp_mem_ctrl i_bsp_mem_ctrl (.clk_i(clk_i), .reset_n_i(reset_n_i), .port(lnk),
        .clk_stop_i(clk_stop), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready_o),
        .cmd_write_i(cmd_write), .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata),
        .cmd_bws_n_i(cmd_bws_n), .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready),
        .rd_data_o(rd_data));
    bsp_link_props #(.AW(8), .DW(18)) i_bsp_link_props (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .k_run(lnk.k_run), .k_rise(lnk.k_rise), .addr(lnk.addr), .d(lnk.d), .q(lnk.q),
        .read_port_select_n(lnk.read_port_select_n), .q_oe_n(lnk.q_oe_n),
        .write_port_select_n(lnk.write_port_select_n),
        .byte_write_select_n(lnk.byte_write_select_n));

    always #10 clk_i = ~clk_i;

    // Hang guard, well above the 150 or so cycles the run needs
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: timeout", $time);
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (err_total == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Offer one command and hold it until taken; idle edge after so valid is low for an edge between commands
    task automatic send(input logic w, input logic [7:0] a, input logic [71:0] wd,
                        input logic [7:0] bn);
        int n;
        n = 0;
        cmd_write = w;
        cmd_addr = a;
        cmd_wdata = wd;
        cmd_bws_n = bn;
        cmd_valid = 1'b1;
        do
        begin
            ok = (cmd_ready_o === 1'b1);
            @(posedge clk_i);
            #1;
            n++;
        end
        while (!ok && n < 400);
        `CHK(ok, 1'b1)
        cmd_valid = 1'b0;
        @(posedge clk_i);
        #1;
    endtask

    // Write burst; the model applies only the lanes whose select is low
    task automatic wr(input logic [7:0] a, input logic [7:0] s, input logic [7:0] bn);
        logic [71:0] wd;
        logic [7:0]  ad;
        for (int b = 0; b < 4; b++)
        begin
            ad = a + b[7:0];
            wd[b*18+:18] = {s, 2'b10, s ^ b[7:0]};
            for (int l = 0; l < 2; l++)
                if (!bn[b*2+l])
                    mem[ad][l*9+:9] = wd[b*18+l*9+:9];
        end
        send(1'b1, a, wd, bn);
    endtask

    // Take one read word, stalling an edge between pops
    task automatic pop(input logic [7:0] ad);
        int n;
        n = 0;
        while (rd_valid_o !== 1'b1 && n < 200)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        `CHK(rd_valid_o, 1'b1)
        `CHK(rd_data, mem[ad])
        rd_ready = 1'b1;
        @(posedge clk_i);
        #1;
        rd_ready = 1'b0;
        @(posedge clk_i);
        #1;
    endtask

    task automatic rd(input logic [7:0] a);
        send(1'b0, a, 72'h0, 8'hFF);
        for (int b = 0; b < 4; b++)
            pop(a + b[7:0]);
    endtask

    // Main sequence
    initial
    begin
        {clk_stop, cmd_valid, cmd_write, rd_ready} = 4'h0;
        {cmd_addr, cmd_wdata, cmd_bws_n} = {8'h00, 72'h0, 8'hFF};
        repeat (2) @(posedge clk_i);
        #1;
        `CHK(lnk.q_oe_n, 1'b1)
        reset_n_i = 1'b1;
        @(posedge clk_i);
        #1;
        wr(8'h10, 8'hA5, 8'h00);
        rd(8'h10);
        wr(8'h10, 8'h3C, 8'h36);
        // Burst still in flight a few edges after the command is taken
        repeat (3) @(posedge clk_i);
        #1;
        `CHK(wr_busy, 1'b1)
        rd(8'h10);
        wr(8'hFE, 8'h5A, 8'h00);
        rd(8'hFE);
        clk_stop = 1'b1;
        repeat (12) @(posedge clk_i);
        #1;
        `CHK(lnk.k_run, 1'b0)
        `CHK(lnk.q_oe_n, 1'b1)
        `CHK(rd_busy, 1'b0)
        `CHK(wr_busy, 1'b0)
        clk_stop = 1'b0;
        // Three reads with no pops: the third must wait for buffer room
        send(1'b0, 8'h10, 72'h0, 8'hFF);
        send(1'b0, 8'hFE, 72'h0, 8'hFF);
        send(1'b0, 8'h10, 72'h0, 8'hFF);
        repeat (40) @(posedge clk_i);
        #1;
        `CHK(cmd_ready_o, 1'b0)
        `CHK(rd_valid_o, 1'b1)
        for (int b = 0; b < 12; b++)
            pop((b / 4 == 1 ? 8'hFE : 8'h10) + 8'(b % 4));
        report_and_stop();
    end
endmodule
